// *** inc/rcl_regs.svh ***
// constants of the reset configuration loader
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH
`define RCL_OPT_ADDR        24'hfffe0e
`define RCL_RATE_LSB        0
`define RCL_RATE_MSB        2
`define RCL_WIN_BIT         3
`define RCL_RATE_RST        3'h0
`define RCL_WIN_RST         1'b0
`define RCL_RAM_INIT_WORDS  16'h0100
`define RCL_LOAD_WORDS      4'h4
`define RCL_RD_TIMEOUT      8'hff
`endif

// *** inc/rcl_pkg.sv ***
// types of the reset configuration loader
package rcl_pkg;
   typedef enum logic [2:0] {
      RCL_IDLE,
      RCL_ABORT,
      RCL_LOAD,
      RCL_WAIT,
      RCL_RAMINIT,
      RCL_RUN
   } rcl_state_e;
   typedef enum logic [1:0] {
      RCL_RST_POR,
      RCL_RST_LVR,
      RCL_RST_WARM
   } rcl_rst_e;
endpackage

// *** src/rcl_sync2.sv ***
// two flop synchroniser
`timescale 1ns/1ps
module rcl_sync2 (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_reg;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         meta_reg <= 1'b0;
         q_o      <= 1'b0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule

// *** src/rcl_counter.sv ***
// loadable down counter with zero flag
`timescale 1ns/1ps
module rcl_counter #(
   parameter int W = 16
) (
   input  wire logic         ref_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] value_i,
   input  wire logic         dec_i,
   output logic [W-1:0]      count_o,
   output logic              zero_o
);
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         count_o <= '0;
      end else if (load_i) begin
         count_o <= value_i;
      end else if (dec_i && count_o != '0) begin
         count_o <= count_o - W'(1);
      end
   end
   assign zero_o = (count_o == '0);
endmodule

// *** src/rcl_loader.sv ***
// reset configuration loader: cpu stall, flash option load, ram init
`timescale 1ns/1ps
`include "rcl_regs.svh"
module rcl_loader
   import rcl_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        por_flag_i,
   input  wire logic        lvr_flag_i,
   input  wire logic        flash_cmd_busy_i,
   input  wire logic        nv_rd_valid_i,
   input  wire logic [7:0]  nv_rd_data_i,
   input  wire logic        nv_dbl_fault_i,
   input  wire logic        ram_init_ack_i,
   output logic             cpu_stall_o,
   output logic             flash_cmd_abort_o,
   output logic             nv_rd_req_o,
   output logic [23:0]      nv_rd_addr_o,
   output logic [2:0]       wdog_rate_sel_o,
   output logic             wdog_window_mode_o,
   output logic             flash_protect_o,
   output logic             flash_secure_o,
   output logic             sysram_init_o,
   output logic             sysram_clear_o,
   output logic             other_ram_init_o,
   output logic             rtc_clear_o,
   output logic             ctrl_init_o
);
   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      rcl_state_e  state;
      rcl_rst_e    rst_kind;
      logic        cpu_stall;
      logic        abort;
      logic        rd_req;
      logic [23:0] rd_addr;
      logic [3:0]  words_left;
      logic [2:0]  rate;
      logic        win;
      logic        wd_done;
      logic        protect;
      logic        secure;
      logic        ram_init;
      logic        ram_clear;
      logic        rtc_clear;
      logic        ctrl_init;
      logic        settle;
   } rcl_loader_s;

   rcl_loader_s st_reg;
   rcl_loader_s st_next;

   logic        busy_s;
   logic        ack_s;
   logic        tmo_load;
   logic        tmo_zero;

   rcl_sync2 u_busy_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (flash_cmd_busy_i),
      .q_o       (busy_s)
   );
   rcl_sync2 u_ack_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (ram_init_ack_i),
      .q_o       (ack_s)
   );
   rcl_counter #(.W(8)) u_tmo (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .load_i    (tmo_load),
      .value_i   (`RCL_RD_TIMEOUT),
      .dec_i     (st_reg.state == RCL_WAIT),
      .count_o   (),
      .zero_o    (tmo_zero)
   );

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      st_next   = st_reg;
      tmo_load  = 1'b0;
      st_next.ctrl_init = 1'b0;
      st_next.rtc_clear = 1'b0;
      st_next.abort     = 1'b0;
      case (st_reg.state)
         RCL_IDLE: begin
            st_next.cpu_stall = 1'b1;
            st_next.ctrl_init = 1'b1;
            st_next.rtc_clear = por_flag_i;
            st_next.rst_kind  = por_flag_i ? RCL_RST_POR :
                                (lvr_flag_i ? RCL_RST_LVR : RCL_RST_WARM);
            st_next.settle    = 1'b1;
            st_next.abort     = 1'b1;
            st_next.wd_done   = 1'b0;
            st_next.protect   = 1'b0;
            st_next.secure    = 1'b0;
            st_next.words_left = `RCL_LOAD_WORDS;
            st_next.rd_addr   = `RCL_OPT_ADDR;
            st_next.state     = RCL_ABORT;
         end
         RCL_ABORT: begin
            if (st_reg.settle) begin
               // busy synchroniser still shows its reset value
               st_next.settle = 1'b0;
               st_next.abort  = 1'b1;
            end else begin
               st_next.abort = busy_s;
               if (!busy_s) begin
                  st_next.state  = RCL_LOAD;
                  st_next.rd_req = 1'b1;
                  tmo_load       = 1'b1;
               end
            end
         end
         RCL_LOAD: begin
            st_next.rd_req = 1'b0;
            st_next.state  = RCL_WAIT;
         end
         RCL_WAIT: begin
            if (nv_rd_valid_i || tmo_zero) begin
               if (nv_dbl_fault_i || !nv_rd_valid_i) begin
                  st_next.protect = 1'b1;
                  st_next.secure  = 1'b1;
               end
               if (nv_rd_valid_i && st_reg.rd_addr == `RCL_OPT_ADDR && !st_reg.wd_done) begin
                  st_next.rate = ~nv_rd_data_i[`RCL_RATE_MSB:`RCL_RATE_LSB];
                  st_next.win = ~nv_rd_data_i[`RCL_WIN_BIT];
                  st_next.wd_done = 1'b1;
               end
               st_next.words_left = st_reg.words_left - 4'h1;
               st_next.rd_addr    = st_reg.rd_addr + 24'h000001;
               if (st_reg.words_left == 4'h1) begin
                  if (st_reg.rst_kind == RCL_RST_WARM) begin
                     st_next.state = RCL_RUN;
                  end else begin
                     st_next.ram_init  = (st_reg.rst_kind == RCL_RST_POR);
                     st_next.ram_clear = 1'b1;
                     st_next.state     = RCL_RAMINIT;
                  end
               end else begin
                  st_next.rd_req = 1'b1;
                  tmo_load       = 1'b1;
                  st_next.state  = RCL_LOAD;
               end
            end
         end
         RCL_RAMINIT: begin
            if (ack_s) begin
               st_next.ram_init  = 1'b0;
               st_next.ram_clear = 1'b0;
               st_next.state     = RCL_RUN;
            end
         end
         RCL_RUN: begin
            st_next.cpu_stall = 1'b0;
         end
         default: st_next.state = RCL_IDLE;
      endcase
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_reg           <= '0;
         st_reg.state     <= RCL_IDLE;
         st_reg.rst_kind  <= RCL_RST_WARM;
         st_reg.cpu_stall <= 1'b1;
         st_reg.rate      <= `RCL_RATE_RST;
         st_reg.win       <= `RCL_WIN_RST;
         st_reg.abort     <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cpu_stall_o        = st_reg.cpu_stall;
   assign flash_cmd_abort_o  = st_reg.abort;
   assign nv_rd_req_o        = st_reg.rd_req;
   assign nv_rd_addr_o       = st_reg.rd_addr;
   assign wdog_rate_sel_o    = st_reg.rate;
   assign wdog_window_mode_o = st_reg.win;
   assign flash_protect_o    = st_reg.protect;
   assign flash_secure_o     = st_reg.secure;
   assign sysram_init_o      = st_reg.ram_init;
   assign sysram_clear_o     = st_reg.ram_clear;
   assign other_ram_init_o   = 1'b0;
   assign rtc_clear_o        = st_reg.rtc_clear;
   assign ctrl_init_o        = st_reg.ctrl_init;

   // ****************************************************
   // checks
   // ****************************************************
   sequence s_opt_read;
      st_reg.state == RCL_WAIT && nv_rd_valid_i && st_reg.rd_addr == `RCL_OPT_ADDR
         && !st_reg.wd_done;
   endsequence
   sequence s_ram_done;
      st_reg.state == RCL_RAMINIT && ack_s;
   endsequence
   sequence s_release;
      st_reg.state == RCL_RUN ##1 !cpu_stall_o;
   endsequence

   a_stall_release: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !cpu_stall_o |-> st_reg.state == RCL_RUN && st_reg.words_left == 4'h0)
      else $error("stall released before load");
   a_fault_lock: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.state == RCL_WAIT && nv_rd_valid_i && nv_dbl_fault_i |=> flash_secure_o && flash_protect_o)
      else $error("double fault did not lock");
   a_abort_busy: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.state == RCL_ABORT && busy_s |=> flash_cmd_abort_o)
      else $error("busy command not aborted");
   a_warm_noram: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.rst_kind == RCL_RST_WARM && st_reg.state != RCL_IDLE |-> !sysram_init_o)
      else $error("ram initialised on warm reset");
   a_other_ram: assert property (@(posedge ref_clk_i) !other_ram_init_o)
      else $error("other ram initialised");
   a_ram_kept: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      sysram_clear_o |-> st_reg.rst_kind != RCL_RST_WARM)
      else $error("ram altered on warm reset");
   a_rate_inv: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_opt_read |=> wdog_rate_sel_o == ~$past(nv_rd_data_i[2:0]))
      else $error("rate not inverted");
   a_win_inv: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_opt_read |=> wdog_window_mode_o == !$past(nv_rd_data_i[3]))
      else $error("window bit not inverted");
   a_once_load: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.wd_done && $stable(st_reg.wd_done) |=> $stable(wdog_rate_sel_o))
      else $error("watchdog config reloaded");
   a_rtc_por: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      rtc_clear_o |-> st_reg.rst_kind == RCL_RST_POR)
      else $error("rtc cleared on non power on reset");
   a_ram_release: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_ram_done |=> s_release)
      else $error("stall not released after ram init");
   a_stall_reset: assert property (@(posedge ref_clk_i)
      sys_rst_i |=> cpu_stall_o)
      else $error("stall not held in reset");
   a_abort_reset: assert property (@(posedge ref_clk_i)
      sys_rst_i |=> flash_cmd_abort_o)
      else $error("command not aborted in reset");
   a_busy_noreq: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.state == RCL_ABORT && busy_s |=> !nv_rd_req_o)
      else $error("read issued while command busy");
   a_opt_first: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.state == RCL_LOAD && st_reg.words_left == `RCL_LOAD_WORDS
         |-> nv_rd_addr_o == `RCL_OPT_ADDR)
      else $error("first read not at option address");
   a_req_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      nv_rd_req_o |=> !nv_rd_req_o)
      else $error("read request longer than one cycle");
   a_por_ram: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.state == RCL_RAMINIT && st_reg.rst_kind == RCL_RST_POR |-> sysram_init_o)
      else $error("ram not initialised on power on");
   a_lvr_noinit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.rst_kind == RCL_RST_LVR && st_reg.state != RCL_IDLE |-> !sysram_init_o)
      else $error("ram initialised on low voltage reset");
   a_lock_pair: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      flash_protect_o == flash_secure_o)
      else $error("protection and security differ");
   a_cfg_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      st_reg.state == RCL_RUN |=> $stable(wdog_rate_sel_o) && $stable(wdog_window_mode_o))
      else $error("watchdog config changed after release");
   a_ctrl_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ctrl_init_o |=> !ctrl_init_o)
      else $error("control init longer than one cycle");
endmodule

// *** verification/rcl_loader_tb.sv ***
// self-checking testbench of the reset configuration loader
`timescale 1ns/1ps
`include "rcl_regs.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
   // ****************************************
   // signals and design under test
   // ****************************************
   logic        ref_clk_i;
   logic        sys_rst_i;
   logic        por_flag_i;
   logic        lvr_flag_i;
   logic        flash_cmd_busy_i;
   logic        nv_rd_valid_i;
   logic [7:0]  nv_rd_data_i;
   logic        nv_dbl_fault_i;
   logic        ram_init_ack_i;
   logic        cpu_stall_o;
   logic        flash_cmd_abort_o;
   logic        nv_rd_req_o;
   logic [23:0] nv_rd_addr_o;
   logic [2:0]  wdog_rate_sel_o;
   logic        wdog_window_mode_o;
   logic        flash_protect_o;
   logic        flash_secure_o;
   logic        sysram_init_o;
   logic        sysram_clear_o;
   logic        other_ram_init_o;
   logic        rtc_clear_o;
   logic        ctrl_init_o;
   int          error_cnt;
   int          n_tests;
   int          cyc_cnt;
   logic [7:0]  opt;

   rcl_loader rcl_loader_inst (
      .ref_clk_i          (ref_clk_i),
      .sys_rst_i          (sys_rst_i),
      .por_flag_i         (por_flag_i),
      .lvr_flag_i         (lvr_flag_i),
      .flash_cmd_busy_i   (flash_cmd_busy_i),
      .nv_rd_valid_i      (nv_rd_valid_i),
      .nv_rd_data_i       (nv_rd_data_i),
      .nv_dbl_fault_i     (nv_dbl_fault_i),
      .ram_init_ack_i     (ram_init_ack_i),
      .cpu_stall_o        (cpu_stall_o),
      .flash_cmd_abort_o  (flash_cmd_abort_o),
      .nv_rd_req_o        (nv_rd_req_o),
      .nv_rd_addr_o       (nv_rd_addr_o),
      .wdog_rate_sel_o    (wdog_rate_sel_o),
      .wdog_window_mode_o (wdog_window_mode_o),
      .flash_protect_o    (flash_protect_o),
      .flash_secure_o     (flash_secure_o),
      .sysram_init_o      (sysram_init_o),
      .sysram_clear_o     (sysram_clear_o),
      .other_ram_init_o   (other_ram_init_o),
      .rtc_clear_o        (rtc_clear_o),
      .ctrl_init_o        (ctrl_init_o)
   );

   // ****************************************
   // clock, timeout and verdict
   // ****************************************
   always #10 ref_clk_i = ~ref_clk_i;

   always @(posedge ref_clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   function automatic logic [2:0] exp_rate(input logic [7:0] b);
      return ~b[`RCL_RATE_MSB:`RCL_RATE_LSB];
   endfunction

   // ****************************************
   // one reset sequence with flash answers
   // ****************************************
   task automatic run_seq(input int kind, input logic [7:0] ob, input logic flt);
      int         k, d, bz, bz0, w, ack, n_ci, n_rtc, n_ab;
      logic       s_init, s_clr, s_oth;
      logic [2:0] r;
      k = 0; d = -1; w = 0; ack = -1; n_ci = 0; n_rtc = 0; n_ab = 0;
      bz = $urandom_range(0, 5);
      bz0 = bz;
      s_init = 0; s_clr = 0; s_oth = 0;
      @(posedge ref_clk_i);
      sys_rst_i <= 1'b1;
      por_flag_i <= (kind == 0);
      lvr_flag_i <= (kind == 1);
      flash_cmd_busy_i <= 1'b1;
      ram_init_ack_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(negedge ref_clk_i);
      `CHK(cpu_stall_o, 1'b1)
      `CHK(flash_cmd_abort_o, 1'b1)
      while (cpu_stall_o === 1'b1 && w < 1500) begin
         n_ci += (ctrl_init_o === 1'b1);
         n_rtc += (rtc_clear_o === 1'b1);
         n_ab += (flash_cmd_abort_o === 1'b1);
         if (sysram_init_o === 1'b1) s_init = 1;
         if (sysram_clear_o === 1'b1) s_clr = 1;
         if (other_ram_init_o !== 1'b0) s_oth = 1;
         if (nv_rd_req_o === 1'b1) begin
            `CHK(nv_rd_addr_o, 24'(`RCL_OPT_ADDR + k))
            `CHK(bz, 0)
            d = $urandom_range(0, 3);
         end
         if ((s_init || s_clr) && ack < 0) ack = 2;
         @(posedge ref_clk_i);
         nv_rd_valid_i <= (d == 0);
         nv_rd_data_i <= (k == 0) ? ob : 8'($urandom);
         nv_dbl_fault_i <= (d == 0) && (k == 0) && flt;
         if (d == 0) k++;
         if (d >= 0) d--;
         if (bz > 0) bz--;
         flash_cmd_busy_i <= (bz > 0);
         if (ack > 0) ack--;
         ram_init_ack_i <= (ack == 0);
         w++;
         @(negedge ref_clk_i);
      end
      r = exp_rate(ob);
      `CHK(w < 1500, 1'b1)
      `CHK(4'(k), `RCL_LOAD_WORDS)
      `CHK(wdog_rate_sel_o, r)
      `CHK(wdog_window_mode_o, ~ob[`RCL_WIN_BIT])
      `CHK(flash_protect_o, flt)
      `CHK(flash_secure_o, flt)
      `CHK(s_init, 1'(kind == 0))
      `CHK(s_clr, 1'(kind != 2))
      `CHK(s_oth, 1'b0)
      `CHK(n_ci, 1)
      `CHK(n_rtc, int'(kind == 0))
      `CHK(n_ab, (bz0 > 1 ? bz0 : 1) + 3)
      // late flash data after release must be ignored
      repeat (4) begin
         @(posedge ref_clk_i);
         nv_rd_valid_i <= 1'b1;
         nv_rd_data_i <= 8'($urandom);
      end
      @(posedge ref_clk_i);
      nv_rd_valid_i <= 1'b0;
      @(negedge ref_clk_i);
      `CHK(wdog_rate_sel_o, r)
      `CHK(wdog_window_mode_o, ~ob[`RCL_WIN_BIT])
      `CHK(cpu_stall_o, 1'b0)
      `CHK(flash_cmd_abort_o, 1'b0)
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(56));
      ref_clk_i = 1'b0;
      sys_rst_i = 1'b1;
      por_flag_i = 1'b1;
      lvr_flag_i = 1'b0;
      flash_cmd_busy_i = 1'b0;
      nv_rd_valid_i = 1'b0;
      nv_rd_data_i = 8'h00;
      nv_dbl_fault_i = 1'b0;
      ram_init_ack_i = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      cyc_cnt = 0;
      for (int i = 0; i < 18; i++) begin
         opt = 8'($urandom);
         if (i < 8) opt[3:0] = {i[0], 3'(i)};
         run_seq(i % 3, opt, (i == 4) || (i == 11));
      end
      end_sim();
   end
endmodule
